// ---- tlvi_unit.v ----
// two-level vectored interrupt unit: pending flags, masks, arbitration, vector call and nesting
// assumes a core sequencer that reports instruction boundaries and return completion,
// and a byte-wide special register port driven synchronously to clk
// Operation
// - twenty-one sources in twenty-two slots, two levels, visible flags
// - flags set regardless of their mask
// - enabled pending source calls at instruction boundary
// - return resumes the interrupted instruction stream
// - global gate bit blocks every source
// - flags persist; re-request right after return
// - software writing one behaves like event; vectoring clear and level-mode pin override the write
// - fifteen peripheral sources, six pin sources
// - pins 0,1 selectable level or edge
// - edge-mode pin flag cleared on vectoring
// - level-mode pin flag tracks the pin
// - pins 4-7 falling edge, port flag bits
// - vector is 0x0003 plus eight times order
// - slot 20 unused, reserved enable reads zero
// - any enabled sub-flag raises its source
// - high preempts low; reset priority low
// - higher level wins, then lowest order
// - decode every clock; five-cycle minimum response
// - one instruction completes after return before call
// - equal or lower waits for return plus one
// - mask register layout with gate bit seven
// - priority one is high; unused bits read one; here only base priority bits 7:6 do, the slot 20 bits read zero
`timescale 1ns/1ps
`include "tlvi_map.vh"
module tlvi_unit #(
  parameter NSRC = `TLVI_NSRC
) (
  input wire clk,                       // system clock, 200 MHz
  input wire reset_n,                   // asynchronous reset, active low
  input wire [7:0] reg_addr,            // special register address
  input wire [7:0] reg_wdata,           // write data
  input wire reg_wr,                    // write strobe, one cycle
  input wire reg_rd,                    // read strobe, one cycle
  input wire [NSRC-1:0] periph_event,   // one-cycle set pulses, bit = order number
  input wire [NSRC-1:0] periph_clear,   // one-cycle clear pulses from peripheral logic
  input wire request_pin0_n,            // pin request 0, active low
  input wire request_pin1_n,            // pin request 1, active low
  input wire [3:0] request_pin47_n,     // pin requests 4..7, active low
  input wire insn_boundary,             // core finishes an instruction this cycle
  input wire call_taken,                // core has started the vector call
  input wire return_done,               // core completed a return from service
  output reg [7:0] reg_rdata,           // read data, valid cycle after reg_rd
  output reg call_request,              // vector call requested, held until call_taken
  output reg [15:0] call_vector,        // target address of the vector call
  output reg [1:0] in_service,          // bit0 low level, bit1 high level
  output reg [NSRC-1:0] pending_out     // current pending flags
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CALL = 2'd1;
  localparam ST_HOLD = 2'd2;

  reg [7:0] core_interrupt_mask_reg;
  reg [7:0] base_priority_register_reg;
  reg [7:0] extended_mask_one_reg;
  reg [7:0] extended_mask_two_reg;
  reg [7:0] extended_prio_one_reg;
  reg [7:0] extended_prio_two_reg;
  reg [1:0] edge_select_reg;
  reg [NSRC-1:0] pending_reg;
  reg [NSRC-1:0] pending_next;
  reg [1:0] pin01_prev_reg;
  reg [3:0] pin47_prev_reg;
  reg [1:0] state_reg;
  reg [4:0] winner_reg;
  reg winner_high_reg;
  reg block_reg;
  reg [NSRC-1:0] enable_vec;
  reg [NSRC-1:0] prio_vec;
  reg [NSRC-1:0] req_vec;
  reg found;
  reg [4:0] pick;
  reg pick_high;
  reg [7:0] rd_mux;
  integer i;

  // vector slots are eight bytes apart, so the order number lands in bits 7:3
  function [15:0] vec_of;
    input [4:0] order;
    begin
      vec_of = `TLVI_VEC_BASE + {8'h00, order, 3'b000};
    end
  endfunction

  // register write decode, shared by the flag logic
  function wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  wire pin0_pending = pending_reg[0];
  wire pin1_pending = pending_reg[2];
  wire global_irq_gate = core_interrupt_mask_reg[`TLVI_GATE_BIT];

  // per-order mask and priority vectors
  // slot 20 is hard zero in both, whatever software wrote there
  always @* begin
    enable_vec = {extended_mask_two_reg[7], 1'b0, extended_mask_two_reg[5:0], extended_mask_one_reg,
                  core_interrupt_mask_reg[5:0]};
    prio_vec = {extended_prio_two_reg[7], 1'b0, extended_prio_two_reg[5:0], extended_prio_one_reg,
                base_priority_register_reg[5:0]};
    req_vec = pending_reg & enable_vec & {NSRC{global_irq_gate}};
  end

  // arbitration: high level first, lowest order among equals
  // loops run downwards so the lowest order written last wins;
  // a running high routine shuts out everything, a running low one
  // only shuts out other low requests
  always @* begin
    found = 1'b0;
    pick = 5'd0;
    pick_high = 1'b0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (req_vec[i] && prio_vec[i] && !in_service[1]) begin
        found = 1'b1;
        pick = i[4:0];
        pick_high = 1'b1;
      end
    end
    if (!pick_high) begin
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (req_vec[i] && !prio_vec[i] && in_service == 2'b00) begin
          found = 1'b1;
          pick = i[4:0];
        end
      end
    end
  end

  // pending flag update; hardware set wins over peripheral, write and vectoring clears
  // order of the steps matters: clears first, then writes,
  // then vectoring clears, then every set source, and the slot 20 tie-off last
  always @* begin
    pending_next = pending_reg & ~periph_clear;

    // software writes load the flags directly; unlike a hardware event, they lose to a vectoring clear; both lose to a level-mode pin
    if (wr_hit(reg_wr, reg_addr, `TLVI_PORTF_ADDR)) begin
      pending_next[19:16] = reg_wdata[7:4];
    end
    if (wr_hit(reg_wr, reg_addr, `TLVI_EDGE_ADDR)) begin
      pending_next[0] = reg_wdata[1];
      pending_next[2] = reg_wdata[3];
    end

    // only edge-mode pin flags are dropped by hardware on vectoring;
    // every other flag stays until its owner clears it
    if (call_taken && state_reg == ST_CALL) begin
      if (winner_reg == 5'd0 && edge_select_reg[0]) begin
        pending_next[0] = 1'b0;
      end
      if (winner_reg == 5'd2 && edge_select_reg[1]) begin
        pending_next[2] = 1'b0;
      end
      if (winner_reg >= 5'd16 && winner_reg <= 5'd19) begin
        pending_next[winner_reg] = 1'b0;
      end
    end

    pending_next = pending_next | periph_event;

    // falling edges of pins 4..7, one flop of history
    pending_next[19:16] = pending_next[19:16] | (pin47_prev_reg & ~request_pin47_n);

    // pin 0: edge mode latches, level mode mirrors the pin
    if (edge_select_reg[0]) begin
      pending_next[0] = pending_next[0] | (pin01_prev_reg[0] & ~request_pin0_n);
    end else begin
      pending_next[0] = ~request_pin0_n;
    end

    // pin 1: same scheme as pin 0
    if (edge_select_reg[1]) begin
      pending_next[2] = pending_next[2] | (pin01_prev_reg[1] & ~request_pin1_n);
    end else begin
      pending_next[2] = ~request_pin1_n;
    end

    // slot 20 has no flag; tie it off so a stray event cannot vector there
    pending_next[`TLVI_UNUSED_SLOT] = 1'b0;
  end

  // read mux; reserved enable and priority bits other than mask spare bit 6 are forced on the way out
  // as well as on the way in, so a stale store can never show
  always @* begin
    case (reg_addr)
      `TLVI_MASK_ADDR: rd_mux = core_interrupt_mask_reg;
      `TLVI_PRIO_ADDR: rd_mux = base_priority_register_reg | `TLVI_PRIO_UNUSED;
      `TLVI_EDGE_ADDR: rd_mux = {4'h0, pin1_pending, edge_select_reg[1], pin0_pending, edge_select_reg[0]};
      `TLVI_PORTF_ADDR: rd_mux = {pending_reg[19:16], 4'h0};
      `TLVI_XMASK_ADDR: rd_mux = extended_mask_one_reg;
      `TLVI_XMASK_ADDR + 8'h01: rd_mux = extended_mask_two_reg & 8'hBF;
      `TLVI_XPRIO_ADDR: rd_mux = extended_prio_one_reg;
      `TLVI_XPRIO_ADDR + 8'h01: rd_mux = extended_prio_two_reg & 8'hBF;
      default: rd_mux = 8'h00;
    endcase
  end

  // register file and flag storage
  // pin history resets to the idle (high) level, so a pin held low
  // through reset is taken as a falling edge right after reset release
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_interrupt_mask_reg <= `TLVI_MASK_RESET;
      base_priority_register_reg <= `TLVI_PRIO_RESET;
      extended_mask_one_reg <= 8'h00;
      extended_mask_two_reg <= 8'h00;
      extended_prio_one_reg <= 8'h00;
      extended_prio_two_reg <= 8'h00;
      edge_select_reg <= 2'b00;
      pending_reg <= {NSRC{1'b0}};
      pin01_prev_reg <= 2'b11;
      pin47_prev_reg <= 4'hF;
      reg_rdata <= 8'h00;
      pending_out <= {NSRC{1'b0}};
    end else begin
      pin01_prev_reg <= {request_pin1_n, request_pin0_n};
      pin47_prev_reg <= request_pin47_n;
      pending_reg <= pending_next;
      pending_out <= pending_next;
      if (reg_rd) reg_rdata <= rd_mux;
      if (reg_wr) begin
        case (reg_addr)
          `TLVI_MASK_ADDR: core_interrupt_mask_reg <= reg_wdata;
          `TLVI_PRIO_ADDR: base_priority_register_reg <= reg_wdata & 8'h3F;
          `TLVI_EDGE_ADDR: edge_select_reg <= {reg_wdata[2], reg_wdata[0]};
          `TLVI_XMASK_ADDR: extended_mask_one_reg <= reg_wdata;
          `TLVI_XMASK_ADDR + 8'h01: extended_mask_two_reg <= reg_wdata & 8'hBF;
          `TLVI_XPRIO_ADDR: extended_prio_one_reg <= reg_wdata;
          `TLVI_XPRIO_ADDR + 8'h01: extended_prio_two_reg <= reg_wdata & 8'hBF;
          default: ;
        endcase
      end
    end
  end

  // call sequencer; block_reg holds off one instruction after a return
  // the hold state gives the flag logic one cycle to drop a vectored
  // edge flag before arbitration may look at it again
  // limitation: a return and a fresh call never overlap, the core
  // is expected to send return_done only outside a vector call
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      winner_reg <= 5'd0;
      winner_high_reg <= 1'b0;
      block_reg <= 1'b0;
      call_request <= 1'b0;
      call_vector <= `TLVI_RESET_VEC;
      in_service <= 2'b00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (return_done) begin
            block_reg <= 1'b1;
            if (in_service[1]) in_service[1] <= 1'b0;
            else in_service[0] <= 1'b0;
          end else if (block_reg) begin
            if (insn_boundary) block_reg <= 1'b0;
          end else if (found && insn_boundary) begin
            state_reg <= ST_CALL;
            winner_reg <= pick;
            winner_high_reg <= pick_high;
            call_request <= 1'b1;
            call_vector <= vec_of(pick);
          end
        end
        ST_CALL: begin
          // pin 0/1 in level mode relies on the requester holding until here
          if (call_taken) begin
            call_request <= 1'b0;
            state_reg <= ST_HOLD;
            if (winner_high_reg) in_service[1] <= 1'b1;
            else in_service[0] <= 1'b1;
          end
        end
        ST_HOLD: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- tlvi_map.vh ----
// register offsets, bit positions and timing counts for the two-level vectored interrupt unit
// included by tlvi_unit.v; definitions only
`ifndef TLVI_MAP_VH
`define TLVI_MAP_VH
`define TLVI_MASK_ADDR 8'hA8
`define TLVI_PRIO_ADDR 8'hB8
`define TLVI_EDGE_ADDR 8'h88
`define TLVI_PORTF_ADDR 8'h8E
`define TLVI_XMASK_ADDR 8'hE8
`define TLVI_XPRIO_ADDR 8'hF8
`define TLVI_MASK_RESET 8'h00
`define TLVI_PRIO_RESET 8'h00
`define TLVI_PRIO_UNUSED 8'hC0
`define TLVI_GATE_BIT 7
`define TLVI_SPARE_BIT 6
`define TLVI_NSRC 22
`define TLVI_UNUSED_SLOT 20
`define TLVI_VEC_BASE 16'h0003
`define TLVI_RESET_VEC 16'h0000
`define TLVI_DETECT_CYC 1
`define TLVI_CALL_CYC 4
`endif

// ---- tlvi_props.sv ----
// assertion checker for the vectored interrupt unit
// bound to tlvi_unit and sees its ports only
`timescale 1ns/1ps
module tlvi_props #(
  parameter NSRC = 22
) (
  input wire clk, // clock
  input wire reset_n, // reset
  input wire [7:0] reg_addr, // address
  input wire [7:0] reg_wdata, // wdata
  input wire reg_wr, // write
  input wire reg_rd, // read
  input wire insn_boundary, // insn end
  input wire call_taken, // taken
  input wire [7:0] reg_rdata, // rdata
  input wire call_request, // call
  input wire [15:0] call_vector, // vector
  input wire [1:0] in_service, // levels
  input wire [NSRC-1:0] pending_out // flags
);
  reg gate_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      gate_reg <= 1'b0;
    else if (reg_wr && reg_addr == 8'hA8)
      gate_reg <= reg_wdata[7];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_call_hold: assert property (call_request && !call_taken |=> call_request && $stable(call_vector))
    else $error("call dropped early");
  chk_call_retire: assert property (call_request && call_taken |=> !call_request && in_service != 2'h0)
    else $error("call not retired");
  chk_vector_grid: assert property (call_request |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h00AB)
    else $error("vector off grid");
  chk_slot_unused: assert property (call_request |-> call_vector != 16'h00A3 && !pending_out[20])
    else $error("unused slot active");
  chk_gate_off: assert property ($rose(call_request) |-> $past(gate_reg))
    else $error("call with gate off");
  chk_at_boundary: assert property ($rose(call_request) |-> $past(insn_boundary))
    else $error("call off boundary");
  chk_prio_pad: assert property (reg_rd && reg_addr == 8'hB8 |=> reg_rdata[7:6] == 2'h3)
    else $error("priority pad bits");
  chk_high_hold: assert property ($rose(call_request) |-> !$past(in_service[1]))
    else $error("high level preempted");
endmodule
bind tlvi_unit tlvi_props #(.NSRC(NSRC)) props_u (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .insn_boundary, .call_taken, .reg_rdata, .call_request, .call_vector, .in_service, .pending_out);

// ---- tlvi_core_model.sv ----
// core sequencer stand-in: instruction ends, vector call, return
// ret_cmd comes from the testbench; shares clock and reset with the unit
`timescale 1ns/1ps
module tlvi_core_model (
  input wire clk, // clock
  input wire reset_n, // reset
  input wire call_request, // call asked
  input wire ret_cmd, // end a routine
  output reg insn_boundary, // insn end
  output reg call_taken, // call started
  output reg return_done // return done
);
  reg [1:0] cnt_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {insn_boundary, call_taken, return_done, cnt_reg} <= 5'h00;
    end else begin
      insn_boundary <= 1'b0;
      call_taken <= 1'b0;
      return_done <= 1'b0;
      if (call_request && !call_taken) begin
        cnt_reg <= cnt_reg + 2'h1; // call spends four cycles
        call_taken <= (cnt_reg == 2'h3);
      end else if (ret_cmd)
        return_done <= 1'b1;
      else
        insn_boundary <= ($urandom % 3 != 0); // multi-cycle instructions
    end
  end
endmodule

// ---- tlvi_tb.sv ----
// self-checking bench for the vectored interrupt unit
// a core model answers calls; pins and events come from here
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [21:0] periph_event = 22'h000000;
  reg [21:0] periph_clear = 22'h000000;
  reg request_pin0_n = 1'b1;
  reg request_pin1_n = 1'b1;
  reg [3:0] request_pin47_n = 4'hF;
  reg ret_cmd = 1'b0;
  reg seen;
  reg [5:0] msk, pri;
  wire insn_boundary, call_taken, return_done, call_request;
  wire [7:0] reg_rdata;
  wire [15:0] call_vector;
  wire [1:0] in_service;
  wire [21:0] pending_out;
  integer errors = 0;
  integer samples_checked = 0;
  integer i, k;
  always #2.5 clk = ~clk;
  tlvi_unit dut_u (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .periph_event, .periph_clear,
    .request_pin0_n, .request_pin1_n, .request_pin47_n, .insn_boundary, .call_taken, .return_done,
    .reg_rdata, .call_request, .call_vector, .in_service, .pending_out);
  tlvi_core_model core_u (.clk, .reset_n, .call_request, .ret_cmd, .insn_boundary, .call_taken, .return_done);
  task chk(input [63:0] nm, input [15:0] s, e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("BAD %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (errors == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wr(input [7:0] a, d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", reg_rdata, e);
    end
  endtask
  task pulse(input [21:0] s, c);
    begin
      @(posedge clk);
      periph_event <= s;
      periph_clear <= c;
      @(posedge clk);
      periph_event <= 22'h0;
      periph_clear <= 22'h0;
    end
  endtask
  task call(input [15:0] v, input [1:0] lv);
    begin
      k = 0;
      while (call_request !== 1'b1 && k < 80) begin
        @(posedge clk);
        #1 k = k + 1;
      end
      chk("vector", call_vector, v);
      repeat (6) @(posedge clk);
      #1 chk("inserv", {14'h0, in_service}, {14'h0, lv});
    end
  endtask
  task quiet;
    begin
      seen = 1'b0;
      repeat (30) @(posedge clk) seen = seen | call_request;
      chk("nocall", {15'h0, seen}, 16'h0);
    end
  endtask
  task ret;
    begin
      @(posedge clk) ret_cmd <= 1'b1;
      @(posedge clk) ret_cmd <= 1'b0;
    end
  endtask
  // lowest order among the winning level takes the call
  function [15:0] win(input [5:0] m, p);
    integer j;
    begin
      win = 16'h0;
      for (j = 5; j >= 0; j = j - 1)
        if (m[j] && (p[j] || !(|(m & p)))) win = 16'h0003 + 8 * j;
    end
  endfunction
  initial begin
    #50000;
    errors = errors + 1;
    tally_and_finish;
  end
  initial begin
    i = $urandom(49);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'hC0);
    rd(8'h00, 8'h00);
    wr(8'hE9, 8'hFF);
    rd(8'hE9, 8'hBF);
    wr(8'hE9, 8'h00);
    wr(8'hA8, 8'h42);
    rd(8'hA8, 8'h42);
    pulse(22'h2, 22'h0);
    quiet;
    chk("pend1", {15'h0, pending_out[1]}, 16'h1);
    wr(8'hA8, 8'h82);
    call(16'h000B, 2'h1);
    ret;
    call(16'h000B, 2'h1);
    pulse(22'h0, 22'h2);
    ret;
    wr(8'hB8, 8'h10);
    wr(8'hA8, 8'h9A);
    pulse(22'h8, 22'h0);
    call(16'h001B, 2'h1);
    pulse(22'h2, 22'h0);
    quiet;
    pulse(22'h10, 22'h0);
    call(16'h0023, 2'h3);
    pulse(22'h0, 22'h1A);
    ret;
    ret;
    wr(8'h88, 8'h01);
    wr(8'hA8, 8'h81);
    @(posedge clk) request_pin0_n <= 1'b0;
    call(16'h0003, 2'h1);
    chk("pin0", {15'h0, pending_out[0]}, 16'h0);
    request_pin0_n <= 1'b1;
    ret;
    wr(8'h88, 8'h00);
    @(posedge clk) request_pin1_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("lvl1", {15'h0, pending_out[2]}, 16'h1);
    request_pin1_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("lvl0", {15'h0, pending_out[2]}, 16'h0);
    wr(8'hA8, 8'h84);
    @(posedge clk) request_pin1_n <= 1'b0;
    call(16'h0013, 2'h1);
    request_pin1_n <= 1'b1;
    ret;
    quiet;
    wr(8'h88, 8'h04);
    wr(8'h88, 8'h0C);
    wr(8'hA8, 8'h84);
    call(16'h0013, 2'h1);
    ret;
    @(posedge clk) request_pin47_n <= 4'h0;
    repeat (3) @(posedge clk);
    rd(8'h8E, 8'hF0);
    request_pin47_n <= 4'hF;
    pulse(22'h0, 22'h0F0000);
    for (i = 0; i < 8; i = i + 1) begin
      msk = $urandom & 6'h3A;
      pri = $urandom;
      if (msk == 6'h0) msk = 6'h10;
      wr(8'hB8, {2'h0, pri});
      wr(8'hA8, {2'h2, msk});
      pulse({16'h0, msk}, 22'h0);
      call(win(msk, pri), (|(msk & pri)) ? 2'h2 : 2'h1);
      pulse(22'h0, 22'h3FFFFF);
      ret;
      repeat (4) @(posedge clk);
    end
    tally_and_finish;
  end
endmodule
